// File: rtl/ctsb_capture_timer.sv
// Capture timer core: prescaler, clock select, noise filter, capture, clear, flag.
// Assumes pin and watch tick inputs are synchronous to clk.
`timescale 1ns/1ps
module ctsb_capture_timer #(
    parameter int CW = ctsb_pkg::COUNTER_WIDTH
) (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire ctsb_pkg::ctsb_cfg_t cfg,
    input  wire logic                watchTick,
    input  wire logic                capturePin,
    input  wire logic                irqFlagClear,
    output logic [CW-1:0]            captureCounter,
    output logic [CW-1:0]            riseCaptureReg,
    output logic [CW-1:0]            fallCaptureReg,
    output logic                     captureSignal,
    output logic                     captureIrqFlag
);
    import ctsb_pkg::*;

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [PRE_WIDTH-1:0]   pre_q;
    logic [WATCH_WIDTH-1:0] watch_q;
    logic [1:0]             clkSel;
    logic [1:0]             clrSel;
    logic                   selLevel;
    logic                   selLevel_q;
    logic                   selLevelPrev_q;
    logic                   countPulse;
    logic                   sampleRise;
    logic                   filterSample;
    logic                   filterSelPrev_q;
    logic                   filterPreset;
    logic                   filterOut;
    logic                   gated_q;
    logic                   gatedPrev_q;
    logic                   edgeRise;
    logic                   edgeFall;
    logic                   clearNow;
    logic                   irqHit;
    logic [CW-1:0]          counter_q;
    logic [CW-1:0]          rise_q;
    logic [CW-1:0]          fall_q;
    logic                   irq_q;

    assign clkSel = {cfg.clockSelectHi, cfg.clockSelectLo};
    assign clrSel = {cfg.counterClearSelHi, cfg.counterClearSelLo};

    // ************************************************************
    // Internal clock generation
    // ************************************************************

    // Free-running system clock prescaler
    always_ff @(posedge clk) begin
        if (rst) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + 1'b1;
        end
    end

    // Watch clock divided by four
    always_ff @(posedge clk) begin
        if (rst) begin
            watch_q <= '0;
        end else if (watchTick) begin
            watch_q <= watch_q + 1'b1;
        end
    end

    // Level of the selected divided clock
    always_comb begin
        unique case (clkSel)
            CLK_SEL_DIV64:  selLevel = pre_q[PRE_BIT_DIV64];
            CLK_SEL_DIV32:  selLevel = pre_q[PRE_BIT_DIV32];
            CLK_SEL_DIV2:   selLevel = pre_q[PRE_BIT_DIV2];
            CLK_SEL_WATCH4: selLevel = watch_q[WATCH_BIT_DIV4];
        endcase
    end

    // Edge history of the muxed clock, so a select switch is seen as an edge
    always_ff @(posedge clk) begin
        if (rst) begin
            selLevel_q     <= 1'b0;
            selLevelPrev_q <= 1'b0;
        end else begin
            selLevel_q     <= selLevel;
            selLevelPrev_q <= selLevel_q;
        end
    end

    // Count on falling edge, sample on rising edge
    assign countPulse = selLevelPrev_q & ~selLevel_q;
    assign sampleRise = ~selLevelPrev_q & selLevel_q;

    // ************************************************************
    // Noise filter
    // ************************************************************

    // Sample every system clock unless filtering is on
    assign filterSample = cfg.noiseFilterSelect ? sampleRise : 1'b1;

    // Filter switch-on detection
    always_ff @(posedge clk) begin
        if (rst) begin
            filterSelPrev_q <= 1'b0;
        end else begin
            filterSelPrev_q <= cfg.noiseFilterSelect;
        end
    end

    // Turning filtering on leaves the output high until five samples settle it
    assign filterPreset = cfg.noiseFilterSelect & ~filterSelPrev_q;

    ctsb_noise_filter #(
        .STAGES (FILTER_STAGES)
    ) uFilter (
        .clk      (clk),
        .rst      (rst),
        .sampleEn (filterSample),
        .preset   (filterPreset),
        .dataIn   (capturePin),
        .dataOut  (filterOut)
    );

    // ************************************************************
    // Internal capture signal and edge detection
    // ************************************************************

    // Pin function gate after the filter, low while disabled
    always_ff @(posedge clk) begin
        if (rst) begin
            gated_q     <= 1'b0;
            gatedPrev_q <= 1'b0;
        end else begin
            gated_q     <= cfg.capturePinEnable & filterOut;
            gatedPrev_q <= gated_q;
        end
    end

    // Edges of the internal capture signal, real or spurious
    assign edgeRise = gated_q & ~gatedPrev_q;
    assign edgeFall = ~gated_q & gatedPrev_q;

    // Counter clear on the selected edge or edges
    always_comb begin
        unique case (clrSel)
            CLEAR_NONE: clearNow = 1'b0;
            CLEAR_FALL: clearNow = edgeFall;
            CLEAR_RISE: clearNow = edgeRise;
            CLEAR_BOTH: clearNow = edgeRise | edgeFall;
        endcase
    end

    // ************************************************************
    // Counter and capture registers
    // ************************************************************

    // Up-counter, clear takes priority over increment
    always_ff @(posedge clk) begin
        if (rst) begin
            counter_q <= COUNTER_RESET;
        end else if (clearNow) begin
            counter_q <= COUNTER_RESET;
        end else if (countPulse) begin
            counter_q <= counter_q + 1'b1;
        end
    end

    // Capture the count before any clear
    always_ff @(posedge clk) begin
        if (rst) begin
            rise_q <= COUNTER_RESET;
            fall_q <= COUNTER_RESET;
        end else begin
            if (edgeRise) begin
                rise_q <= counter_q;
            end
            if (edgeFall) begin
                fall_q <= counter_q;
            end
        end
    end

    // ************************************************************
    // Interrupt request flag
    // ************************************************************

    // Edge matching the interrupt edge select
    assign irqHit = (cfg.captureIrqEdgeSelect == IRQ_EDGE_RISE) ? edgeRise : edgeFall;

    // Sticky flag, a new edge beats a simultaneous clear
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else if (irqHit) begin
            irq_q <= 1'b1;
        end else if (irqFlagClear) begin
            irq_q <= 1'b0;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign captureCounter = counter_q;
    assign riseCaptureReg = rise_q;
    assign fallCaptureReg = fall_q;
    assign captureSignal  = gated_q;
    assign captureIrqFlag = irq_q;
endmodule

// File: rtl/ctsb_pkg.sv
// Constants, field codes and carrier types of the 8-bit capture timer.
// Assumes a single 100 MHz system clock and a synchronous active-high reset.
package ctsb_pkg;

    // ************************************************************
    // Widths and reset values
    // ************************************************************
    localparam int                  COUNTER_WIDTH = 8;
    localparam logic [7:0]          COUNTER_RESET = 8'h00;
    localparam int                  FILTER_STAGES = 5;
    localparam int                  PRE_WIDTH     = 6;
    localparam int                  WATCH_WIDTH   = 2;

    // ************************************************************
    // Prescaler taps for the divided internal clocks
    // ************************************************************
    localparam int                  PRE_BIT_DIV2  = 0;
    localparam int                  PRE_BIT_DIV32 = 4;
    localparam int                  PRE_BIT_DIV64 = 5;
    localparam int                  WATCH_BIT_DIV4 = 1;

    // ************************************************************
    // Field codes
    // ************************************************************
    localparam logic [1:0]          CLK_SEL_DIV64   = 2'h0;
    localparam logic [1:0]          CLK_SEL_DIV32   = 2'h1;
    localparam logic [1:0]          CLK_SEL_DIV2    = 2'h2;
    localparam logic [1:0]          CLK_SEL_WATCH4  = 2'h3;
    localparam logic [1:0]          CLEAR_NONE      = 2'h0;
    localparam logic [1:0]          CLEAR_FALL      = 2'h1;
    localparam logic [1:0]          CLEAR_RISE      = 2'h2;
    localparam logic [1:0]          CLEAR_BOTH      = 2'h3;
    localparam logic                IRQ_EDGE_FALL   = 1'b0;
    localparam logic                IRQ_EDGE_RISE   = 1'b1;

    // ************************************************************
    // Carrier types
    // ************************************************************
    typedef struct packed {
        logic       clockSelectHi;
        logic       clockSelectLo;
        logic       capturePinEnable;
        logic       noiseFilterSelect;
        logic       captureIrqEdgeSelect;
        logic       counterClearSelHi;
        logic       counterClearSelLo;
    } ctsb_cfg_t;

endpackage

// File: rtl/ctsb_noise_filter.sv
// Five-latch digital noise filter with a match detector.
// Assumes sampleEn is in the clk domain: a one-cycle pulse, or held high to sample every cycle.
`timescale 1ns/1ps
module ctsb_noise_filter #(
    parameter int STAGES = ctsb_pkg::FILTER_STAGES
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic sampleEn,
    input  wire logic preset,
    input  wire logic dataIn,
    output logic      dataOut
);
    import ctsb_pkg::*;

    logic [STAGES-1:0] chain_q;
    logic [STAGES-1:0] chain_d;
    logic              out_q;

    // Next contents of the latch chain
    always_comb begin
        chain_d = {chain_q[STAGES-2:0], dataIn};
    end

    // Shift on sample, accept level only when all latches agree
    always_ff @(posedge clk) begin
        if (rst) begin
            chain_q <= '0;
            out_q   <= 1'b0;
        end else if (preset) begin
            chain_q <= '1;             // Stale high state after switching filter on
            out_q   <= 1'b1;
        end else if (sampleEn) begin
            chain_q <= chain_d;
            if (&chain_d) begin
                out_q <= 1'b1;
            end else if (~|chain_d) begin
                out_q <= 1'b0;
            end
        end
    end

    assign dataOut = out_q;
endmodule

// File: dv/ctsb_pulse_src.sv
// External pulse source on the capture pin.
// Assumes the bench requests levels in the clk domain.
`timescale 1ns/1ps
module ctsb_pulse_src (
    input  wire logic clk,
    input  wire logic level,
    output logic      pin
);
    // Idle low until the first request
    initial pin = 1'b0;
    // Pin follows the requested level one edge later
    always @(posedge clk) begin
        pin <= level;
    end
endmodule

// File: dv/ctsb_capture_timer_properties.sv
// Port-level checks of the capture timer.
// Assumes binding to ctsb_capture_timer; single clock domain.
`timescale 1ns/1ps
module ctsb_capture_timer_properties
    import ctsb_pkg::*;
#(
    parameter int CW = 8
) (
    input wire logic                clk,
    input wire logic                rst,
    input wire ctsb_pkg::ctsb_cfg_t cfg,
    input wire logic                watchTick,
    input wire logic                capturePin,
    input wire logic                irqFlagClear,
    input wire logic [CW-1:0]       captureCounter,
    input wire logic [CW-1:0]       riseCaptureReg,
    input wire logic [CW-1:0]       fallCaptureReg,
    input wire logic                captureSignal,
    input wire logic                captureIrqFlag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ************************************************************
    // Counter, capture, flag and filter relations
    // ************************************************************
    a_count_step: assert property (captureCounter == $past(captureCounter)
        || captureCounter == CW'($past(captureCounter) + 1) || captureCounter == '0)
        else $error("counter moved by more than one");
    a_rise_copy: assert property ($rose(captureSignal)
        |=> riseCaptureReg == $past(captureCounter)) else $error("rise capture wrong");
    a_fall_copy: assert property ($fell(captureSignal)
        |=> fallCaptureReg == $past(captureCounter)) else $error("fall capture wrong");
    a_clear_rise: assert property ($rose(captureSignal) && cfg.counterClearSelHi
        |=> captureCounter == '0) else $error("no clear on rising edge");
    a_clear_fall: assert property ($fell(captureSignal) && cfg.counterClearSelLo
        |=> captureCounter == '0) else $error("no clear on falling edge");
    a_flag_set: assert property (($rose(captureSignal) && cfg.captureIrqEdgeSelect)
        || ($fell(captureSignal) && !cfg.captureIrqEdgeSelect) |=> captureIrqFlag)
        else $error("matching edge did not set flag");
    a_flag_hold: assert property (captureIrqFlag && !irqFlagClear |=> captureIrqFlag)
        else $error("flag dropped without clear");
    a_flag_clear: assert property (irqFlagClear && !$changed(captureSignal)
        |=> !captureIrqFlag) else $error("flag not cleared");
    a_pin_off: assert property (!cfg.capturePinEnable |=> !captureSignal)
        else $error("capture signal high while pin function off");
    a_filter_pass: assert property ((cfg.capturePinEnable && !cfg.noiseFilterSelect
        && capturePin) [*7] |=> captureSignal) else $error("steady high not passed");
    // Main scenarios
    c_rise: cover property ($rose(captureSignal) && cfg.captureIrqEdgeSelect);
    c_fall: cover property ($fell(captureSignal) && !cfg.captureIrqEdgeSelect);
    c_clear: cover property (irqFlagClear && captureIrqFlag);
endmodule
bind ctsb_capture_timer ctsb_capture_timer_properties #(.CW(CW)) u_props (
    .clk(clk), .rst(rst), .cfg(cfg), .watchTick(watchTick), .capturePin(capturePin),
    .irqFlagClear(irqFlagClear), .captureCounter(captureCounter),
    .riseCaptureReg(riseCaptureReg), .fallCaptureReg(fallCaptureReg),
    .captureSignal(captureSignal), .captureIrqFlag(captureIrqFlag));

// File: dv/capture_timer_switch_behaviour_tb_top.sv
// Self-checking bench of the capture timer.
// Assumes the pulse source model and the bound checker.
`timescale 1ns/1ps
module capture_timer_switch_behaviour_tb_top;
    import ctsb_pkg::*;
    logic       clk, rst, watchTick, irqFlagClear, pinReq, capturePin;
    logic [7:0] captureCounter, riseCaptureReg, fallCaptureReg, c0;
    logic       captureSignal, captureIrqFlag;
    ctsb_cfg_t  cfg;
    int         n_mismatch = 0;
    int         checks = 0;
    int         cyc = 0;
    ctsb_capture_timer #(.CW(8)) dut (.clk(clk), .rst(rst), .cfg(cfg),
        .watchTick(watchTick), .capturePin(capturePin), .irqFlagClear(irqFlagClear),
        .captureCounter(captureCounter), .riseCaptureReg(riseCaptureReg),
        .fallCaptureReg(fallCaptureReg), .captureSignal(captureSignal),
        .captureIrqFlag(captureIrqFlag));
    ctsb_pulse_src u_src (.clk(clk), .level(pinReq), .pin(capturePin));
    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic ctsb_cfg_t mk(input logic e, input logic n, input logic i);
        mk = ctsb_cfg_t'({CLK_SEL_DIV2, e, n, i, CLEAR_BOTH});
    endfunction
    task automatic chk(input logic ok, input string m);
        checks++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t %s", $time, m);
        end
    endtask
    task automatic tick();
        @(posedge clk) watchTick <= 1'b1;
        @(posedge clk) watchTick <= 1'b0;
        @(posedge clk) watchTick <= 1'b1;
        @(posedge clk) watchTick <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    // Settle, clear the flag, then two configuration steps
    task automatic spur(input logic pa, input logic pb, input logic pc, input ctsb_cfg_t a,
        input ctsb_cfg_t b, input ctsb_cfg_t c, input int d, input logic ex, input string m);
        @(posedge clk) begin cfg <= a; pinReq <= pa; end
        repeat (20) @(posedge clk);
        irqFlagClear <= 1'b1;
        @(posedge clk) irqFlagClear <= 1'b0;
        @(posedge clk) begin cfg <= b; pinReq <= pb; end
        repeat (d) @(posedge clk);
        cfg <= c;
        pinReq <= pc;
        repeat (20) @(posedge clk);
        #1 chk(captureIrqFlag === ex, m);
        $display("test %s done", m);
    endtask
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ************************************************************
    // Clock, timeout and main sequence
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    initial begin
        rst = 1'b1;
        watchTick = 1'b0;
        irqFlagClear = 1'b0;
        pinReq = 1'b0;
        cfg = ctsb_cfg_t'({CLK_SEL_WATCH4, 5'h00});
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        tick();
        chk(captureCounter === 8'h00, "rising clock counted");
        tick();
        chk(captureCounter === 8'h01, "falling clock not counted");
        tick();
        cfg <= ctsb_cfg_t'({CLK_SEL_DIV64, 5'h00});
        repeat (5) @(posedge clk);
        chk(captureCounter === 8'h02, "switch high to low not counted");
        cfg <= ctsb_cfg_t'({CLK_SEL_DIV2, 5'h00});
        repeat (4) @(posedge clk);
        c0 = captureCounter;
        repeat (20) @(posedge clk);
        chk(captureCounter - c0 === 8'h0A, "div2 rate");
        cfg <= ctsb_cfg_t'({CLK_SEL_DIV32, 5'h00});
        repeat (4) @(posedge clk);
        c0 = captureCounter;
        repeat (64) @(posedge clk);
        chk(captureCounter - c0 === 8'h02, "div32 rate");
        $display("test counter done");
        spur(1, 1, 1, mk(0, 0, 1), mk(1, 0, 1), mk(1, 0, 1), 1, 1, "en_rise");
        spur(1, 1, 1, mk(0, 0, 0), mk(1, 0, 0), mk(1, 0, 0), 1, 0, "opposite");
        spur(1, 1, 1, mk(1, 0, 0), mk(0, 0, 0), mk(0, 0, 0), 1, 1, "en_fall");
        spur(1, 1, 1, mk(0, 0, 1), mk(0, 1, 1), mk(1, 1, 1), 2, 1, "flt_en_hi");
        spur(0, 0, 0, mk(0, 0, 0), mk(0, 1, 0), mk(1, 1, 0), 2, 1, "flt_en_lo");
        spur(1, 1, 1, mk(1, 0, 0), mk(1, 1, 0), mk(0, 1, 0), 20, 1, "late_off");
        spur(0, 1, 1, mk(1, 0, 1), mk(1, 0, 1), mk(1, 1, 1), 2, 1, "pin_flt_on");
        spur(1, 0, 0, mk(1, 1, 0), mk(1, 1, 0), mk(1, 0, 0), 2, 1, "pin_flt_off");
        spur(0, 0, 0, mk(1, 0, 1), mk(0, 0, 1), mk(0, 1, 1), 2, 0, "off_first");
        spur(0, 1, 0, mk(1, 0, 1), mk(1, 0, 1), mk(1, 0, 1), 3, 0, "glitch");
        @(posedge clk) pinReq <= 1'b1;
        repeat (40) @(posedge clk);
        pinReq <= 1'b0;
        repeat (12) @(posedge clk);
        #1 chk(fallCaptureReg >= 8'h13 && fallCaptureReg <= 8'h14, "high width");
        @(posedge clk) pinReq <= 1'b1;
        repeat (12) @(posedge clk);
        #1 chk(riseCaptureReg === 8'h06, "low width");
        chk(captureSignal === 1'b1, "capture signal not high");
        $display("test width done");
        give_verdict();
    end
endmodule
